/* verilog/ssf_servo_status.sv */
`timescale 1ns/1ps
// Function
// - bit 9 follows servo ready
// - bit 10 high throughout homing
// - bit 11 high while gain two used
// - bit 12 flags encoder battery low
// - bit 13 when supply at/below threshold
// - bit 14 when speed at/below stop threshold
// - bit 16 mirrors brake released output
// - bits 22:20 carry alarm category
// - bit 24 pulses 10 ms on arrival
// - alarm code captured on detection
// - bit 3 when stopped by alarm
// - bit 2 when deviation within range
module ssf_servo_status #(
  parameter int unsigned ARRIVE_CYCLES = ssf_pkg::ARRIVE_PULSE_CYC,
  parameter int unsigned IN_W          = 8,
  parameter int unsigned OUT_W         = 5
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              servo_on,
  input  wire logic              profile_busy,
  input  wire logic              fwd_limit,
  input  wire logic              rev_limit,
  input  wire logic              torque_limit,
  input  wire logic              speed_limit,
  input  wire logic              deviation_excess,
  input  wire logic              servo_ready,
  input  wire logic              homing_active,
  input  wire logic              gain2_active,
  input  wire logic              battery_low,
  input  wire logic [15:0]       drive_voltage,
  input  wire logic              brake_released,
  input  wire logic              alarm_stop,
  input  wire logic              alarm_detect,
  input  wire logic [2:0]        alarm_category,
  input  wire logic [31:0]       alarm_code,
  input  wire logic              target_reached,
  input  wire logic [31:0]       position_deviation,
  input  wire logic [31:0]       fb_position,
  input  wire logic [31:0]       fb_speed,
  input  wire logic [31:0]       fb_current,
  input  wire logic [31:0]       sensor_position,
  input  wire logic [IN_W-1:0]   digital_inputs,
  input  wire logic [OUT_W-1:0]  digital_outputs,
  output logic                   irq
);

  // ==========================================================
  // helpers
  function automatic logic [31:0] magnitude(input logic [31:0] v);
    magnitude = v[31] ? (~v + 32'h0000_0001) : v;
  endfunction

  function automatic logic [47:0] pack48(input logic [31:0] pos,
                                         input logic [31:0] spd,
                                         input logic [31:0] cur);
    pack48 = {pos[15:0], spd[15:0], cur[15:0]};
  endfunction

  // ==========================================================
  // declarations
  logic [IN_W-1:0]                 din_meta_ff;
  logic [IN_W-1:0]                 din_sync_ff;
  logic [31:0]                     status_word_ff;
  logic [31:0]                     io_word_ff;
  logic [31:0]                     alarm_code_ff;
  logic [31:0]                     fb_pos_ff;
  logic [31:0]                     fb_spd_ff;
  logic [31:0]                     fb_cur_ff;
  logic [47:0]                     pack_psc_ff;
  logic [47:0]                     pack_ssc_ff;
  logic [15:0]                     supply_thresh_ff;
  logic [31:0]                     stop_speed_ff;
  logic [31:0]                     inpos_range_ff;
  logic [ssf_pkg::IRQ_W-1:0]       irq_status_ff;
  logic [ssf_pkg::IRQ_W-1:0]       irq_mask_ff;
  logic                            battery_low_d_ff;
  logic                            supply_loss_d_ff;
  logic                            arrived_pulse;
  logic                            supply_loss;
  logic                            stopped;
  logic                            in_position;
  logic                            addr_ok;
  logic                            accept;
  logic                            wr_pend_ff;
  logic                            rd_pend_ff;
  logic [5:0]                      addr_idx_ff;
  logic                            wr_fire;
  logic [ssf_pkg::IRQ_W-1:0]       irq_events;
  logic [ssf_pkg::IRQ_W-1:0]       irq_clear;
  logic [31:0]                     nxt_rdata;

  // ==========================================================
  // pin inputs pass two flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      din_meta_ff <= '0;
      din_sync_ff <= '0;
    end else if (ce) begin
      din_meta_ff <= digital_inputs;
      din_sync_ff <= din_meta_ff;
    end
  end

  // ==========================================================
  // arrival pulse
  ssf_pulse_timer #(
    .CYCLES (ARRIVE_CYCLES)
  ) u_arrive (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .start   (target_reached),
    .pulse   (arrived_pulse)
  );

  // ==========================================================
  // threshold comparisons
  assign supply_loss = (drive_voltage <= supply_thresh_ff);
  // speed sign ignored: stop judgement is on magnitude
  assign stopped     = (magnitude(fb_speed) <= stop_speed_ff);
  assign in_position = (magnitude(position_deviation) <= inpos_range_ff);

  // ==========================================================
  // servo status word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_word_ff <= 32'h0000_0000;
    end else if (ce) begin
      status_word_ff <= 32'h0000_0000;
      status_word_ff[ssf_pkg::SSW_SERVO_ON]     <= servo_on;
      status_word_ff[ssf_pkg::SSW_PROFILE_BUSY] <= profile_busy;
      status_word_ff[ssf_pkg::SSW_IN_POSITION]  <= in_position;
      status_word_ff[ssf_pkg::SSW_ALARM_STOP]   <= alarm_stop;
      status_word_ff[ssf_pkg::SSW_FWD_LIMIT]    <= fwd_limit;
      status_word_ff[ssf_pkg::SSW_REV_LIMIT]    <= rev_limit;
      status_word_ff[ssf_pkg::SSW_TORQUE_LIMIT] <= torque_limit;
      status_word_ff[ssf_pkg::SSW_SPEED_LIMIT]  <= speed_limit;
      // deviation flag drops once the alarm has stopped the motor
      status_word_ff[ssf_pkg::SSW_DEVIATION]    <= deviation_excess && !alarm_stop;
      status_word_ff[ssf_pkg::SSW_READY]        <= servo_ready;
      status_word_ff[ssf_pkg::SSW_HOMING]       <= homing_active;
      status_word_ff[ssf_pkg::SSW_GAIN2]        <= gain2_active;
      status_word_ff[ssf_pkg::SSW_BATTERY_LOW]  <= battery_low;
      status_word_ff[ssf_pkg::SSW_SUPPLY_LOSS]  <= supply_loss;
      status_word_ff[ssf_pkg::SSW_STOPPED]      <= stopped;
      status_word_ff[ssf_pkg::SSW_BRAKE_REL]    <= brake_released;
      status_word_ff[ssf_pkg::SSW_ALARM_CAT_LO +: 3] <= alarm_category;
      status_word_ff[ssf_pkg::SSW_ARRIVED]      <= arrived_pulse;
    end
  end

  // ==========================================================
  // io word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_word_ff <= 32'h0000_0000;
    end else if (ce) begin
      io_word_ff <= 32'h0000_0000;
      io_word_ff[ssf_pkg::IO_IN_LO +: IN_W]   <= din_sync_ff;
      io_word_ff[ssf_pkg::IO_OUT_LO +: OUT_W] <= digital_outputs;
    end
  end

  // ==========================================================
  // alarm code capture, held until the next alarm
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_code_ff <= 32'h0000_0000;
    end else if (ce && alarm_detect) begin
      alarm_code_ff <= alarm_code;
    end
  end

  // ==========================================================
  // feedback snapshot, both packs taken on the same edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fb_pos_ff   <= 32'h0000_0000;
      fb_spd_ff   <= 32'h0000_0000;
      fb_cur_ff   <= 32'h0000_0000;
      pack_psc_ff <= 48'h0000_0000_0000;
      pack_ssc_ff <= 48'h0000_0000_0000;
    end else if (ce) begin
      fb_pos_ff   <= fb_position;
      fb_spd_ff   <= fb_speed;
      fb_cur_ff   <= fb_current;
      pack_psc_ff <= pack48(fb_position, fb_speed, fb_current);
      pack_ssc_ff <= pack48(sensor_position, fb_speed, fb_current);
    end
  end

  // ==========================================================
  // ahb-lite slave: writes zero wait, reads one wait
  assign addr_ok = (haddr[31:ssf_pkg::ADDR_DEC_W] == '0) && (haddr[1:0] == 2'b00);
  assign accept  = hsel && htrans[1] && hready;
  assign wr_fire = wr_pend_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff  <= 1'b0;
      rd_pend_ff  <= 1'b0;
      addr_idx_ff <= 6'h00;
    end else if (ce) begin
      wr_pend_ff <= accept && hwrite && addr_ok;
      rd_pend_ff <= accept && !hwrite;
      if (accept) begin
        addr_idx_ff <= addr_ok ? haddr[7:2] : 6'h3F;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= !(accept && !hwrite);
      hresp     <= 1'b0;
    end
  end

  // the wait cycle lets a write just before a read land first
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (addr_idx_ff)
      ssf_pkg::IDX_SERVO_STATUS_WORD: nxt_rdata = status_word_ff;
      ssf_pkg::IDX_IO_PIN_STATUS:     nxt_rdata = io_word_ff;
      ssf_pkg::IDX_ALARM_CODE_VALUE:  nxt_rdata = alarm_code_ff;
      ssf_pkg::IDX_FEEDBACK_POSITION: nxt_rdata = fb_pos_ff;
      ssf_pkg::IDX_FEEDBACK_SPEED:    nxt_rdata = fb_spd_ff;
      ssf_pkg::IDX_FEEDBACK_CURRENT:  nxt_rdata = fb_cur_ff;
      ssf_pkg::IDX_PACK_PSC_LO:       nxt_rdata = pack_psc_ff[31:0];
      ssf_pkg::IDX_PACK_SSC_LO:       nxt_rdata = pack_ssc_ff[31:0];
      ssf_pkg::IDX_PACK_PSC_HI:       nxt_rdata = {16'h0000, pack_psc_ff[47:32]};
      ssf_pkg::IDX_PACK_SSC_HI:       nxt_rdata = {16'h0000, pack_ssc_ff[47:32]};
      ssf_pkg::IDX_SUPPLY_THRESHOLD:  nxt_rdata = {16'h0000, supply_thresh_ff};
      ssf_pkg::IDX_STOP_SPEED_THRESH: nxt_rdata = stop_speed_ff;
      ssf_pkg::IDX_INPOS_RANGE:       nxt_rdata = inpos_range_ff;
      ssf_pkg::IDX_IRQ_STATUS:        nxt_rdata = {28'h000_0000, irq_status_ff};
      ssf_pkg::IDX_IRQ_MASK:          nxt_rdata = {28'h000_0000, irq_mask_ff};
      default:                        nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      hrdata <= rd_pend_ff ? nxt_rdata : 32'h0000_0000;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      supply_thresh_ff <= ssf_pkg::RST_SUPPLY_THRESHOLD;
      stop_speed_ff    <= ssf_pkg::RST_STOP_SPEED;
      inpos_range_ff   <= ssf_pkg::RST_INPOS_RANGE;
      irq_mask_ff      <= ssf_pkg::RST_IRQ_MASK;
    end else if (ce && wr_fire) begin
      if (addr_idx_ff == ssf_pkg::IDX_SUPPLY_THRESHOLD) begin
        supply_thresh_ff <= hwdata[15:0];
      end
      if (addr_idx_ff == ssf_pkg::IDX_STOP_SPEED_THRESH) begin
        stop_speed_ff <= hwdata;
      end
      if (addr_idx_ff == ssf_pkg::IDX_INPOS_RANGE) begin
        inpos_range_ff <= hwdata;
      end
      if (addr_idx_ff == ssf_pkg::IDX_IRQ_MASK) begin
        irq_mask_ff <= hwdata[ssf_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================
  // interrupts: sticky, write one to clear, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      battery_low_d_ff <= 1'b0;
      supply_loss_d_ff <= 1'b0;
    end else if (ce) begin
      battery_low_d_ff <= battery_low;
      supply_loss_d_ff <= supply_loss;
    end
  end

  always_comb begin
    irq_events                        = '0;
    irq_events[ssf_pkg::IRQ_ALARM]    = alarm_detect;
    irq_events[ssf_pkg::IRQ_ARRIVED]  = target_reached;
    irq_events[ssf_pkg::IRQ_BATTERY]  = battery_low && !battery_low_d_ff;
    irq_events[ssf_pkg::IRQ_SUPPLY]   = supply_loss && !supply_loss_d_ff;
    irq_clear = (wr_fire && addr_idx_ff == ssf_pkg::IDX_IRQ_STATUS) ?
                hwdata[ssf_pkg::IRQ_W-1:0] : '0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_ff <= '0;
    end else if (ce) begin
      irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_events;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(((irq_status_ff & ~irq_clear) | irq_events) & irq_mask_ff);
    end
  end

endmodule

/* verilog/ssf_pkg.sv */
package ssf_pkg;

  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned ARRIVE_PULSE_MS = 10;
  localparam int unsigned ARRIVE_PULSE_CYC = (CLK_HZ / 1000) * ARRIVE_PULSE_MS;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_SERVO_STATUS_WORD = 6'h14;
  localparam logic [5:0] IDX_IO_PIN_STATUS     = 6'h15;
  localparam logic [5:0] IDX_ALARM_CODE_VALUE  = 6'h16;
  localparam logic [5:0] IDX_FEEDBACK_POSITION = 6'h28;
  localparam logic [5:0] IDX_FEEDBACK_SPEED    = 6'h29;
  localparam logic [5:0] IDX_FEEDBACK_CURRENT  = 6'h2A;
  localparam logic [5:0] IDX_PACK_PSC_LO       = 6'h2B;
  localparam logic [5:0] IDX_PACK_SSC_LO       = 6'h2C;
  localparam logic [5:0] IDX_PACK_PSC_HI       = 6'h2D;
  localparam logic [5:0] IDX_PACK_SSC_HI       = 6'h2E;
  localparam logic [5:0] IDX_SUPPLY_THRESHOLD  = 6'h30;
  localparam logic [5:0] IDX_STOP_SPEED_THRESH = 6'h31;
  localparam logic [5:0] IDX_INPOS_RANGE       = 6'h32;
  localparam logic [5:0] IDX_IRQ_STATUS        = 6'h33;
  localparam logic [5:0] IDX_IRQ_MASK          = 6'h34;
  localparam int unsigned ADDR_DEC_W           = 8;

  // ==========================================================
  // servo status word bit positions
  localparam int unsigned SSW_SERVO_ON     = 0;
  localparam int unsigned SSW_PROFILE_BUSY = 1;
  localparam int unsigned SSW_IN_POSITION  = 2;
  localparam int unsigned SSW_ALARM_STOP   = 3;
  localparam int unsigned SSW_FWD_LIMIT    = 4;
  localparam int unsigned SSW_REV_LIMIT    = 5;
  localparam int unsigned SSW_TORQUE_LIMIT = 6;
  localparam int unsigned SSW_SPEED_LIMIT  = 7;
  localparam int unsigned SSW_DEVIATION    = 8;
  localparam int unsigned SSW_READY        = 9;
  localparam int unsigned SSW_HOMING       = 10;
  localparam int unsigned SSW_GAIN2        = 11;
  localparam int unsigned SSW_BATTERY_LOW  = 12;
  localparam int unsigned SSW_SUPPLY_LOSS  = 13;
  localparam int unsigned SSW_STOPPED      = 14;
  localparam int unsigned SSW_BRAKE_REL    = 16;
  localparam int unsigned SSW_ALARM_CAT_LO = 20;
  localparam int unsigned SSW_ARRIVED      = 24;

  // io word layout
  localparam int unsigned IO_IN_LO  = 0;
  localparam int unsigned IO_OUT_LO = 8;

  // ==========================================================
  // interrupt status bits
  localparam int unsigned IRQ_ALARM   = 0;
  localparam int unsigned IRQ_ARRIVED = 1;
  localparam int unsigned IRQ_BATTERY = 2;
  localparam int unsigned IRQ_SUPPLY  = 3;
  localparam int unsigned IRQ_W       = 4;

  // ==========================================================
  // reset values
  localparam logic [15:0]     RST_SUPPLY_THRESHOLD = 16'h0000;
  localparam logic [31:0]     RST_STOP_SPEED       = 32'h0000_0000;
  localparam logic [31:0]     RST_INPOS_RANGE      = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK        = 4'h0;

endpackage

/* verilog/ssf_pulse_timer.sv */
`timescale 1ns/1ps
module ssf_pulse_timer #(
  parameter int unsigned CYCLES = 500000
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic start,
  output logic      pulse
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_ff;

  // ==========================================================
  // retrigger restarts the full width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_ff <= '0;
    end else if (ce) begin
      if (start) begin
        count_ff <= CW'(CYCLES);
      end else if (count_ff != '0) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse <= 1'b0;
    end else if (ce) begin
      pulse <= start || (count_ff > CW'(1));
    end
  end

endmodule

/* tb/ssf_servo_status_asserts.sv */
`timescale 1ns/1ps
// ==========================================
// read wait-state check and read-back checks against settled inputs
module ssf_servo_status_checker #(
  parameter int unsigned OUT_W = 5
) (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             ce,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic [31:0]      hrdata,
  input wire logic             servo_ready,
  input wire logic             homing_active,
  input wire logic             gain2_active,
  input wire logic             battery_low,
  input wire logic             brake_released,
  input wire logic             alarm_stop,
  input wire logic [2:0]       alarm_category,
  input wire logic [OUT_W-1:0] digital_outputs,
  input wire logic [31:0]      fb_speed,
  input wire logic [31:0]      fb_current
);
  logic [40+OUT_W:0] cur_v;
  logic [40+OUT_W:0] prev_ff;
  logic [2:0]        quiet_ff;
  logic [7:0]        raddr_ff;
  logic              hro_ff;
  logic              done;
  logic              rd_take;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign cur_v = {servo_ready, homing_active, gain2_active, battery_low, brake_released, alarm_stop,
                  alarm_category, digital_outputs, fb_speed[15:0], fb_current[15:0]};
  assign rd_take = hsel & htrans[1] & hready & ce & ~hwrite;
  // inputs pass register stages first, so only reads of settled inputs are judged
  assign done = hreadyout & ~hro_ff & (quiet_ff == 3'h4);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_ff  <= '0;
      quiet_ff <= 3'h0;
      hro_ff   <= 1'b1;
    end else begin
      prev_ff  <= cur_v;
      quiet_ff <= (cur_v != prev_ff) ? 3'h0 : ((quiet_ff == 3'h4) ? 3'h4 : quiet_ff + 3'h1);
      hro_ff   <= hreadyout;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raddr_ff <= 8'h00;
    end else if (rd_take) begin
      raddr_ff <= haddr[7:0];
    end
  end
  a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_ready_bit: assert property (done && raddr_ff == 8'h50 |-> hrdata[9] == servo_ready)
    else $error("ready bit wrong");
  a_homing_bit: assert property (done && raddr_ff == 8'h50 |-> hrdata[10] == homing_active)
    else $error("homing bit wrong");
  a_gain_bit: assert property (done && raddr_ff == 8'h50 |-> hrdata[11] == gain2_active)
    else $error("gain bit wrong");
  a_battery_bit: assert property (done && raddr_ff == 8'h50 |-> hrdata[12] == battery_low)
    else $error("battery bit wrong");
  a_brake_bit: assert property (done && raddr_ff == 8'h50 |-> hrdata[16] == brake_released)
    else $error("brake bit wrong");
  a_alarm_cat: assert property (done && raddr_ff == 8'h50 |-> hrdata[22:20] == alarm_category)
    else $error("alarm category wrong");
  a_alarm_stop: assert property (done && raddr_ff == 8'h50 |-> hrdata[3] == alarm_stop)
    else $error("alarm stop bit wrong");
  a_io_outputs: assert property (done && raddr_ff == 8'h54 |-> hrdata[12:8] == digital_outputs)
    else $error("output states wrong");
  a_pack_low: assert property (done && raddr_ff == 8'hAC |-> hrdata == {fb_speed[15:0], fb_current[15:0]})
    else $error("pack low word wrong");
endmodule

bind ssf_servo_status ssf_servo_status_checker #(.OUT_W(OUT_W)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
  .servo_ready(servo_ready), .homing_active(homing_active), .gain2_active(gain2_active),
  .battery_low(battery_low), .brake_released(brake_released), .alarm_stop(alarm_stop),
  .alarm_category(alarm_category), .digital_outputs(digital_outputs), .fb_speed(fb_speed),
  .fb_current(fb_current));

/* tb/ssf_host_model.sv */
`timescale 1ns/1ps
// ==========================================
// bus master standing in for the motion controller
module ssf_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // no cycle count assumed: waits on hready, only the bench watchdog ends a hang
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
endmodule

/* tb/tb_servo_status_feedback.sv */
`timescale 1ns/1ps
module tb_servo_status_feedback;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic        alarm_detect, target_reached;
  logic [16:0] flg;
  logic [2:0]  alarm_category, hsize;
  logic [1:0]  htrans;
  logic [15:0] drive_voltage;
  logic [31:0] alarm_code, position_deviation, fb_position, fb_speed, fb_current, sensor_position;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [7:0]  digital_inputs;
  logic [4:0]  digital_outputs;
  int          fails, n_compared;
  int          bl[13] = '{0, 1, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 16};
  logic [31:0] ta[9] = '{32'h54, 32'hA0, 32'hA4, 32'hA8, 32'hAC, 32'hB0, 32'hB4, 32'hB8, 32'h0C};
  logic [31:0] te[9] = '{32'h16A5, 32'h1111_ABCD, 32'h10, 32'h321, 32'h0010_0321, 32'h0010_0321,
                         32'hABCD, 32'h5678, 32'h0};

  ssf_servo_status #(.ARRIVE_CYCLES(20)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .servo_on(flg[0]), .profile_busy(flg[1]), .fwd_limit(flg[4]),
    .rev_limit(flg[5]), .torque_limit(flg[6]), .speed_limit(flg[7]), .deviation_excess(flg[8]),
    .servo_ready(flg[9]), .homing_active(flg[10]), .gain2_active(flg[11]), .battery_low(flg[12]),
    .drive_voltage(drive_voltage), .brake_released(flg[16]), .alarm_stop(flg[3]),
    .alarm_detect(alarm_detect), .alarm_category(alarm_category), .alarm_code(alarm_code),
    .target_reached(target_reached), .position_deviation(position_deviation), .fb_position(fb_position),
    .fb_speed(fb_speed), .fb_current(fb_current), .sensor_position(sensor_position),
    .digital_inputs(digital_inputs), .digital_outputs(digital_outputs), .irq(irq));

  ssf_host_model i_host (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // ==========================================
  // access and comparison helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rdv);
  endtask
  task automatic rd(input logic [31:0] a);
    i_host.xfer(1'b0, a, 32'hA5A5_5A5A, rdv);
  endtask
  task automatic st(input logic [31:0] e);
    repeat (4) @(posedge hclk);
    rd(32'h50);
    chk(rdv, e);
  endtask
  task automatic summarize();
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    repeat (5000) @(posedge hclk);
    fails++;
    summarize();
  end

  // ==========================================
  // test sequence
  initial begin
    hresetn = 1'b0;
    flg = 17'h0;
    alarm_detect = 1'b0;
    target_reached = 1'b0;
    alarm_category = 3'h0;
    drive_voltage = 16'h0100;
    alarm_code = 32'h0;
    position_deviation = 32'h5;
    fb_position = 32'h0;
    fb_speed = 32'h10;
    fb_current = 32'h0;
    sensor_position = 32'h0;
    digital_inputs = 8'h00;
    digital_outputs = 5'h00;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) begin
      rd(32'hC0 + 32'h4 * i);
      chk(rdv, 32'h0);
    end
    chk({31'h0, irq}, 32'h0);
    foreach (bl[i]) begin
      flg <= 17'h1 << bl[i];
      st(32'h1 << bl[i]);
    end
    flg <= 17'h0_0108;
    st(32'h8);
    flg <= 17'h0;
    alarm_category <= 3'h5;
    st(32'h0050_0000);
    wr(32'hC0, 32'h100);
    st(32'h0050_2000);
    wr(32'hC0, 32'hFF);
    st(32'h0050_0000);
    wr(32'hC4, 32'h10);
    st(32'h0050_4000);
    fb_speed <= 32'hFFFF_FFEF;
    st(32'h0050_0000);
    wr(32'hC8, 32'h5);
    st(32'h0050_0004);
    position_deviation <= 32'hFFFF_FFFA;
    st(32'h0050_0000);
    wr(32'hCC, 32'hF);
    alarm_code <= 32'h1234_00AB;
    alarm_detect <= 1'b1;
    @(posedge hclk);
    alarm_detect <= 1'b0;
    alarm_code <= 32'h77;
    rd(32'h58);
    chk(rdv, 32'h1234_00AB);
    rd(32'hCC);
    chk(rdv, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(32'hD0, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    wr(32'hCC, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    target_reached <= 1'b1;
    @(posedge hclk);
    target_reached <= 1'b0;
    repeat (12) @(posedge hclk);
    rd(32'h50);
    chk(rdv, 32'h0150_0000);
    repeat (12) @(posedge hclk);
    rd(32'h50);
    chk(rdv, 32'h0050_0000);
    digital_inputs <= 8'hA5;
    digital_outputs <= 5'h16;
    fb_position <= 32'h1111_ABCD;
    fb_speed <= 32'h10;
    fb_current <= 32'h321;
    sensor_position <= 32'h2222_5678;
    wr(32'hA0, 32'hFFFF_FFFF);
    repeat (4) @(posedge hclk);
    foreach (ta[i]) begin
      rd(ta[i]);
      chk(rdv, te[i]);
    end
    summarize();
  end
endmodule
